// ==== rtl/lioreg_bank.v ====
// low i/o register bank: three port triplets, timer and pin-change flags
// Contract
// - single bits at 0x00-0x1F set or cleared directly
// - skip instructions can test one bit there
// - status flags clear on one, zero keeps
// - bit set/clear touches only addressed bit
// - io instructions use six-bit address 0x00-0x3F
// - data-space alias is io address plus 0x20
// - extended region 0x60-0xFF via load/store only
// - port d input, direction, output at 0x09-0x0B
// - port c triplet at 0x06-0x08, bit 7 reserved
// - port b triplet at 0x03-0x05
// - timer0 flags at 0x15: b, a, overflow
// - timer1 flags at 0x16 plus capture bit 5
// - timer2 flags at 0x17: b, a, overflow
// - pin-change flags at 0x1B bits 2..0
`timescale 1ns/10ps
`include "lioreg_defines.vh"

module lioreg_bank (
  input  wire       core_clk,
  input  wire       rst_b,
  input  wire       clk_en,
  input  wire [2:0] op_code,
  input  wire [7:0] op_addr,
  input  wire [2:0] op_bit,
  input  wire [7:0] op_wdata,
  input  wire [7:0] port_b_pins,
  input  wire [7:0] port_c_pins,
  input  wire [7:0] port_d_pins,
  input  wire [2:0] timer0_events,
  input  wire [2:0] timer0_hw_clear,
  input  wire [3:0] timer1_events,
  input  wire [3:0] timer1_hw_clear,
  input  wire [2:0] timer2_events,
  input  wire [2:0] timer2_hw_clear,
  input  wire [2:0] pin_change_events,
  output reg  [7:0] rdata_reg,
  output reg        rvalid_reg,
  output reg        bit_value_reg,
  output reg        ext_sel_reg,
  output reg        bad_access_reg,
  output reg  [7:0] port_b_direction_bits,
  output reg  [7:0] port_b_output_bits,
  output reg  [7:0] port_c_direction_bits,
  output reg  [7:0] port_c_output_bits,
  output reg  [7:0] port_d_direction_bits,
  output reg  [7:0] port_d_output_bits,
  output reg  [7:0] timer0_flags,
  output reg  [7:0] timer1_flags,
  output reg  [7:0] timer2_flags,
  output reg  [7:0] pin_change_flags
);

  reg        rst_sync1_reg;
  reg        rst_sync2_reg;
  reg  [7:0] port_b_input_level;
  reg  [7:0] port_c_input_level;
  reg  [7:0] port_d_input_level;

  // collected event vectors, positioned at their register bits
  wire [7:0] t0_set;
  wire [7:0] t0_hw;
  wire [7:0] t1_set;
  wire [7:0] t1_hw;
  wire [7:0] t2_set;
  wire [7:0] t2_hw;
  wire [7:0] pc_set;

  reg        is_io;
  reg        is_rd;
  reg        is_wr;
  reg        is_bit;
  reg  [5:0] io_addr;
  reg  [7:0] mem_addr;
  reg        ext_hit;
  reg  [7:0] bit_mask;
  reg  [7:0] cur_val;
  reg  [7:0] wr_val;
  reg  [7:0] w1c_val;
  reg        mapped;

  // reset released through two flops, asserted asynchronously
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  assign t0_set = {5'h00, timer0_events};
  assign t0_hw  = {5'h00, timer0_hw_clear};
  assign t1_set = {2'h0, timer1_events[3], 2'h0, timer1_events[2:0]};
  assign t1_hw  = {2'h0, timer1_hw_clear[3], 2'h0, timer1_hw_clear[2:0]};
  assign t2_set = {5'h00, timer2_events};
  assign t2_hw  = {5'h00, timer2_hw_clear};
  assign pc_set = {5'h00, pin_change_events};

  // map a six-bit io address to its implemented bits
  function [7:0] lio_impl_mask;
    input [5:0] a;
    begin
      case (a)
        `LIO_PORT_B_OUTPUT_IN, `LIO_PORT_B_OUTPUT_DIR, `LIO_PORT_B_OUTPUT_OUT,
        `LIO_PORT_D_OUTPUT_IN, `LIO_PORT_D_OUTPUT_DIR, `LIO_PORT_D_OUTPUT_OUT:
          lio_impl_mask = 8'hFF;
        `LIO_PORT_C_OUTPUT_IN, `LIO_PORT_C_OUTPUT_DIR, `LIO_PORT_C_OUTPUT_OUT:
          lio_impl_mask = `LIO_PORT_C_OUTPUT_MASK;
        `LIO_T0_FLAGS: lio_impl_mask = `LIO_T0_MASK;
        `LIO_T1_FLAGS: lio_impl_mask = `LIO_T1_MASK;
        `LIO_T2_FLAGS: lio_impl_mask = `LIO_T2_MASK;
        `LIO_PC_FLAGS: lio_impl_mask = `LIO_PC_MASK;
        default:       lio_impl_mask = 8'h00;
      endcase
    end
  endfunction

  // flag update: hardware set beats any clear in the same cycle
  function [7:0] lio_flag_next;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] sw_clr;
    input [7:0] hw_clr;
    input [7:0] mask;
    begin
      lio_flag_next = ((cur & ~sw_clr & ~hw_clr) | set) & mask;
    end
  endfunction

  // decode of the access
  always @* begin
    is_io   = (op_code == `LIO_OP_IO_READ) || (op_code == `LIO_OP_IO_WRITE);
    is_bit  = (op_code == `LIO_OP_BIT_SET) ||
              (op_code == `LIO_OP_BIT_CLEAR) ||
              (op_code == `LIO_OP_BIT_TEST);
    is_rd   = (op_code == `LIO_OP_IO_READ) ||
              (op_code == `LIO_OP_MEM_READ);
    is_wr   = (op_code == `LIO_OP_IO_WRITE) ||
              (op_code == `LIO_OP_MEM_WRITE);
    ext_hit = 1'b0;
    mapped  = 1'b1;
    io_addr = op_addr[5:0];
    mem_addr = op_addr - `LIO_DATA_OFFSET;
    if (is_io || is_bit) begin
      io_addr = op_addr[5:0];
      if (op_addr > `LIO_IO_LAST)
        mapped = 1'b0;
      if (is_bit && (op_addr[5:0] > `LIO_BIT_LAST))
        mapped = 1'b0;
    end else if (op_code != `LIO_OP_NONE) begin
      // load/store see the bank shifted up by the alias offset
      // the alias offset is below 0x40, so six bits keep the register index
      io_addr = mem_addr[5:0];
      if (op_addr >= `LIO_EXT_FIRST) begin
        ext_hit = 1'b1;
        mapped  = 1'b0;
      end else if (op_addr < `LIO_DATA_OFFSET) begin
        mapped  = 1'b0;
      end
    end
    bit_mask = 8'h01 << op_bit;
    case (io_addr)
      `LIO_PORT_B_OUTPUT_IN:  cur_val = port_b_input_level;
      `LIO_PORT_B_OUTPUT_DIR: cur_val = port_b_direction_bits;
      `LIO_PORT_B_OUTPUT_OUT: cur_val = port_b_output_bits;
      `LIO_PORT_C_OUTPUT_IN:  cur_val = port_c_input_level;
      `LIO_PORT_C_OUTPUT_DIR: cur_val = port_c_direction_bits;
      `LIO_PORT_C_OUTPUT_OUT: cur_val = port_c_output_bits;
      `LIO_PORT_D_OUTPUT_IN:  cur_val = port_d_input_level;
      `LIO_PORT_D_OUTPUT_DIR: cur_val = port_d_direction_bits;
      `LIO_PORT_D_OUTPUT_OUT: cur_val = port_d_output_bits;
      `LIO_T0_FLAGS:  cur_val = timer0_flags;
      `LIO_T1_FLAGS:  cur_val = timer1_flags;
      `LIO_T2_FLAGS:  cur_val = timer2_flags;
      `LIO_PC_FLAGS:  cur_val = pin_change_flags;
      default:        cur_val = 8'h00;
    endcase
    cur_val = cur_val & lio_impl_mask(io_addr) & {8{mapped}};
    // plain registers: read-modify-write of the one bit
    wr_val = op_wdata;
    if (op_code == `LIO_OP_BIT_SET)
      wr_val = cur_val | bit_mask;
    else if (op_code == `LIO_OP_BIT_CLEAR)
      wr_val = cur_val & ~bit_mask;
    // flag registers: a bit set clears only the addressed flag
    w1c_val = 8'h00;
    if (is_wr)
      w1c_val = op_wdata;
    else if (op_code == `LIO_OP_BIT_SET)
      w1c_val = bit_mask;
    if (!mapped || !(is_wr || op_code == `LIO_OP_BIT_SET ||
        op_code == `LIO_OP_BIT_CLEAR)) begin
      w1c_val = 8'h00;
    end
  end

  always @(posedge core_clk or negedge rst_sync2_reg) begin
    if (!rst_sync2_reg) begin
      port_b_input_level    <= `LIO_RESET_BYTE;
      port_c_input_level    <= `LIO_RESET_BYTE;
      port_d_input_level    <= `LIO_RESET_BYTE;
      port_b_direction_bits <= `LIO_RESET_BYTE;
      port_b_output_bits    <= `LIO_RESET_BYTE;
      port_c_direction_bits <= `LIO_RESET_BYTE;
      port_c_output_bits    <= `LIO_RESET_BYTE;
      port_d_direction_bits <= `LIO_RESET_BYTE;
      port_d_output_bits    <= `LIO_RESET_BYTE;
      timer0_flags          <= `LIO_RESET_BYTE;
      timer1_flags          <= `LIO_RESET_BYTE;
      timer2_flags          <= `LIO_RESET_BYTE;
      pin_change_flags      <= `LIO_RESET_BYTE;
      rdata_reg             <= `LIO_RESET_BYTE;
      rvalid_reg            <= 1'b0;
      bit_value_reg         <= 1'b0;
      ext_sel_reg           <= 1'b0;
      bad_access_reg        <= 1'b0;
    end else if (clk_en) begin
      // pins are sampled each cycle that clk_en is high; input registers are read only
      port_b_input_level <= port_b_pins;
      port_c_input_level <= port_c_pins & `LIO_PORT_C_OUTPUT_MASK;
      port_d_input_level <= port_d_pins;
      rvalid_reg    <= mapped && (is_rd || op_code == `LIO_OP_BIT_TEST);
      rdata_reg     <= is_rd ? cur_val : `LIO_RESET_BYTE;
      bit_value_reg <= (op_code == `LIO_OP_BIT_TEST) &&
                       (|(cur_val & bit_mask));
      ext_sel_reg   <= ext_hit;
      // out-of-range addresses are harmless, but the core is told
      bad_access_reg <= (op_code != `LIO_OP_NONE) &&
                        !mapped && !ext_hit;
      if (mapped && (is_wr || op_code == `LIO_OP_BIT_SET ||
          op_code == `LIO_OP_BIT_CLEAR)) begin
        case (io_addr)
          `LIO_PORT_B_OUTPUT_DIR: port_b_direction_bits <= wr_val;
          `LIO_PORT_B_OUTPUT_OUT: port_b_output_bits    <= wr_val;
          `LIO_PORT_C_OUTPUT_DIR:
            port_c_direction_bits <= wr_val & `LIO_PORT_C_OUTPUT_MASK;
          `LIO_PORT_C_OUTPUT_OUT:
            port_c_output_bits    <= wr_val & `LIO_PORT_C_OUTPUT_MASK;
          `LIO_PORT_D_OUTPUT_DIR: port_d_direction_bits <= wr_val;
          `LIO_PORT_D_OUTPUT_OUT: port_d_output_bits    <= wr_val;
          default: ;
        endcase
      end
      timer0_flags <= lio_flag_next(timer0_flags, t0_set,
        (io_addr == `LIO_T0_FLAGS) ? w1c_val : 8'h00, t0_hw,
        `LIO_T0_MASK);
      timer1_flags <= lio_flag_next(timer1_flags, t1_set,
        (io_addr == `LIO_T1_FLAGS) ? w1c_val : 8'h00, t1_hw,
        `LIO_T1_MASK);
      timer2_flags <= lio_flag_next(timer2_flags, t2_set,
        (io_addr == `LIO_T2_FLAGS) ? w1c_val : 8'h00, t2_hw,
        `LIO_T2_MASK);
      pin_change_flags <= lio_flag_next(pin_change_flags, pc_set,
        (io_addr == `LIO_PC_FLAGS) ? w1c_val : 8'h00, 8'h00,
        `LIO_PC_MASK);
    end
  end

endmodule

// ==== rtl/lioreg_defines.vh ====
// address map, field positions and reset values of the low i/o register bank
`ifndef LIOREG_DEFINES_VH
`define LIOREG_DEFINES_VH

`define LIO_DATA_OFFSET  8'h20
`define LIO_IO_LAST      8'h3F
`define LIO_BIT_LAST     6'h1F
`define LIO_EXT_FIRST    8'h60

`define LIO_PORT_B_OUTPUT_IN     6'h03
`define LIO_PORT_B_OUTPUT_DIR    6'h04
`define LIO_PORT_B_OUTPUT_OUT    6'h05
`define LIO_PORT_C_OUTPUT_IN     6'h06
`define LIO_PORT_C_OUTPUT_DIR    6'h07
`define LIO_PORT_C_OUTPUT_OUT    6'h08
`define LIO_PORT_D_OUTPUT_IN     6'h09
`define LIO_PORT_D_OUTPUT_DIR    6'h0A
`define LIO_PORT_D_OUTPUT_OUT    6'h0B
`define LIO_T0_FLAGS     6'h15
`define LIO_T1_FLAGS     6'h16
`define LIO_T2_FLAGS     6'h17
`define LIO_PC_FLAGS     6'h1B

`define LIO_PORT_C_OUTPUT_MASK   8'h7F
`define LIO_T0_MASK      8'h07
`define LIO_T1_MASK      8'h27
`define LIO_T2_MASK      8'h07
`define LIO_PC_MASK      8'h07
`define LIO_OVF_BIT      0
`define LIO_MATCH_A_BIT  1
`define LIO_MATCH_B_BIT  2
`define LIO_CAPTURE_BIT  5

`define LIO_RESET_BYTE   8'h00

`define LIO_OP_NONE      3'h0
`define LIO_OP_IO_READ   3'h1
`define LIO_OP_IO_WRITE  3'h2
`define LIO_OP_MEM_READ  3'h3
`define LIO_OP_MEM_WRITE 3'h4
`define LIO_OP_BIT_SET   3'h5
`define LIO_OP_BIT_CLEAR 3'h6
`define LIO_OP_BIT_TEST  3'h7

`endif

// ==== test/lioreg_core_model.sv ====
// core-side model: issues one i/o or memory op per call
`timescale 1ns/10ps
module lioreg_core_model (
  input  wire       core_clk,
  output reg  [2:0] op_code  = 3'h0,
  output reg  [7:0] op_addr  = 8'h00,
  output reg  [2:0] op_bit   = 3'h0,
  output reg  [7:0] op_wdata = 8'h00
);
  task issue(input [2:0] c, input [7:0] a, input [2:0] b, input [7:0] d);
    begin
      @(negedge core_clk);
      op_code  = c;
      op_addr  = a;
      op_bit   = b;
      op_wdata = d;
      @(negedge core_clk);
      // idle bus shows junk so a stale value cannot pass for a request
      op_code  = 3'h0;
      op_addr  = ~a;
      op_wdata = ~d;
    end
  endtask
endmodule

// ==== test/lioreg_checker_assertions.sv ====
// concurrent checks on the low i/o register bank ports
`timescale 1ns/10ps
module lioreg_checker (
  input wire       core_clk,
  input wire       rst_b,
  input wire       clk_en,
  input wire [2:0] op_code,
  input wire [7:0] op_addr,
  input wire [2:0] op_bit,
  input wire [7:0] op_wdata,
  input wire [2:0] timer0_events,
  input wire [3:0] timer1_events,
  input wire       rvalid_reg,
  input wire [7:0] rdata_reg,
  input wire       ext_sel_reg,
  input wire       bad_access_reg,
  input wire [7:0] port_b_output_bits,
  input wire [7:0] port_d_direction_bits,
  input wire [7:0] timer0_flags,
  input wire [7:0] timer1_flags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // timer0 events kept quiet so a set cannot mask a clear
  sequence s_take(c, a);
    clk_en && op_code == c && op_addr == a && !timer0_events;
  endsequence
  property p_io_wr;
    s_take(3'h2, 8'h05) |=> port_b_output_bits == $past(op_wdata);
  endproperty
  a_io_wr: assert property (p_io_wr) else $error("io write lost");
  property p_alias;
    s_take(3'h4, 8'h2A) |=> port_d_direction_bits == $past(op_wdata);
  endproperty
  a_alias: assert property (p_alias) else $error("alias lost");
  property p_ext;
    clk_en && op_code inside {3'h3, 3'h4} && op_addr >= 8'h60 |=> ext_sel_reg;
  endproperty
  a_ext: assert property (p_ext) else $error("ext not flagged");
  property p_bad;
    clk_en && op_code inside {3'h1, 3'h2} && op_addr > 8'h3F
      |=> bad_access_reg && !rvalid_reg;
  endproperty
  a_bad: assert property (p_bad) else $error("range not refused");
  property p_w1c;
    s_take(3'h2, 8'h15)
      |=> timer0_flags == ($past(timer0_flags) & ~$past(op_wdata));
  endproperty
  a_w1c: assert property (p_w1c) else $error("one-clear wrong");
  property p_bitset;
    s_take(3'h5, 8'h15)
      |=> timer0_flags == ($past(timer0_flags) & ~(8'h01 << $past(op_bit)));
  endproperty
  a_bitset: assert property (p_bitset) else $error("bit op spill");
  property p_cap;
    clk_en && timer1_events[3] |=> timer1_flags[5] ##1 timer1_flags[5];
  endproperty
  a_cap: assert property (p_cap) else $error("capture lost");
  property p_resv;
    s_take(3'h1, 8'h0C) |=> rvalid_reg && rdata_reg == 8'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved not 0");
endmodule
bind lioreg_bank lioreg_checker lioreg_checker_inst (
  .core_clk, .rst_b, .clk_en, .op_code, .op_addr, .op_bit, .op_wdata,
  .timer0_events, .timer1_events, .rvalid_reg, .rdata_reg, .ext_sel_reg,
  .bad_access_reg, .port_b_output_bits, .port_d_direction_bits,
  .timer0_flags, .timer1_flags
);

// ==== test/test_lioreg_bank.sv ====
// self-checking bench for the low i/o register bank
`timescale 1ns/10ps
module test_lioreg_bank;
  reg        core_clk = 1'b0;
  reg        rst_b    = 1'b0;
  reg        clk_en   = 1'b1;
  reg  [3:0] t1_ev    = 4'h0;
  reg  [2:0] t0_ev    = 3'h0;
  reg  [2:0] t2_ev    = 3'h0;
  reg  [2:0] t2_hc    = 3'h0;
  reg  [2:0] pc_ev    = 3'h0;
  reg  [7:0] d, a, pv;
  wire [2:0] op_code, op_bit;
  wire [7:0] op_addr, op_wdata, rdata, pbo;
  wire       rvalid, bitv, ext, bad;
  integer    n_fail = 0, tests_run = 0, cyc = 0, i;
  always #10 core_clk = ~core_clk;
  lioreg_core_model core_model_inst (.core_clk(core_clk), .op_code(op_code),
    .op_addr(op_addr), .op_bit(op_bit), .op_wdata(op_wdata));
  lioreg_bank lioreg_bank_inst (.core_clk(core_clk), .rst_b(rst_b),
    .clk_en(clk_en), .op_code(op_code), .op_addr(op_addr), .op_bit(op_bit),
    .op_wdata(op_wdata), .port_b_pins(8'h5A), .port_c_pins(8'hFF),
    .port_d_pins(8'h3C), .timer0_events(t0_ev), .timer0_hw_clear(3'h0),
    .timer1_events(t1_ev), .timer1_hw_clear(4'h0), .timer2_events(t2_ev),
    .timer2_hw_clear(t2_hc), .pin_change_events(pc_ev), .rdata_reg(rdata),
    .rvalid_reg(rvalid), .bit_value_reg(bitv), .ext_sel_reg(ext),
    .bad_access_reg(bad), .port_b_direction_bits(), .port_b_output_bits(pbo),
    .port_c_direction_bits(), .port_c_output_bits(),
    .port_d_direction_bits(), .port_d_output_bits(), .timer0_flags(),
    .timer1_flags(), .timer2_flags(), .pin_change_flags());
  task summarize;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task op(input [2:0] c, input [7:0] ad, input [2:0] b, input [7:0] dd);
    core_model_inst.issue(c, ad, b, dd);
  endtask
  task rd(input [2:0] c, input [7:0] ad, input [7:0] e);
    begin
      op(c, ad, 3'h0, 8'h00);
      chk(rdata, e);
      chk({7'h00, rvalid}, 8'h01);
    end
  endtask
  task rf(input [2:0] c, input [7:0] ad, input [7:0] e);
    begin
      op(c, ad, 3'h0, 8'h00);
      chk({5'h00, ext, bad, rvalid}, e);
    end
  endtask
  // hang guard: the whole run needs well under 600 cycles
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_fail = n_fail + 1;
      summarize;
    end
  end
  initial begin
    repeat (8) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge core_clk);
    for (i = 0; i < 28; i = i + 1) begin
      pv = (i == 3) ? 8'h5A : (i == 6) ? 8'h7F : (i == 9) ? 8'h3C : 8'h00;
      rd(3'h1, i[7:0], pv);
    end
    for (i = 3; i < 12; i = i + 1) begin
      d  = {i[3:0], ~i[3:0]} | 8'h80;
      a  = i[0] ? i[7:0] : i[7:0] + 8'h20;
      pv = (i == 3) ? 8'h5A : (i == 6) ? 8'h7F : (i == 9) ? 8'h3C
         : (i == 7 || i == 8) ? (d & 8'h7F) : d;
      op(i[0] ? 3'h2 : 3'h4, a, 3'h0, d);
      rd(3'h3, i[7:0] + 8'h20, pv);
    end
    op(3'h5, 8'h05, 3'h0, 8'h00);
    chk(pbo, 8'hDB);
    op(3'h6, 8'h05, 3'h7, 8'h00);
    chk(pbo, 8'h5B);
    op(3'h7, 8'h05, 3'h1, 8'h00);
    chk({6'h00, bitv, rvalid}, 8'h03);
    op(3'h7, 8'h05, 3'h2, 8'h00);
    chk({6'h00, bitv, rvalid}, 8'h01);
    @(negedge core_clk) {t1_ev, t0_ev, t2_ev, pc_ev} = 13'h1FFF;
    @(negedge core_clk) {t1_ev, t0_ev, t2_ev, pc_ev} = 13'h0000;
    rd(3'h1, 8'h15, 8'h07);
    rd(3'h1, 8'h16, 8'h27);
    rd(3'h1, 8'h17, 8'h07);
    rd(3'h1, 8'h1B, 8'h07);
    op(3'h5, 8'h15, 3'h0, 8'h00);
    rd(3'h1, 8'h15, 8'h06);
    op(3'h6, 8'h15, 3'h1, 8'h00);
    rd(3'h1, 8'h15, 8'h06);
    op(3'h2, 8'h15, 3'h0, 8'h04);
    rd(3'h1, 8'h15, 8'h02);
    op(3'h2, 8'h15, 3'h0, 8'h00);
    rd(3'h1, 8'h15, 8'h02);
    op(3'h4, 8'h3B, 3'h0, 8'hFF);
    rd(3'h1, 8'h1B, 8'h00);
    @(negedge core_clk) t2_hc = 3'h2;
    @(negedge core_clk) t2_hc = 3'h0;
    rd(3'h1, 8'h17, 8'h05);
    rf(3'h1, 8'h40, 8'h02);
    rf(3'h4, 8'h60, 8'h04);
    rf(3'h3, 8'h10, 8'h02);
    rf(3'h5, 8'h20, 8'h02);
    clk_en = 1'b0;
    op(3'h2, 8'h05, 3'h0, 8'h00);
    chk(pbo, 8'h5B);
    clk_en = 1'b1;
    summarize;
  end
endmodule
